// File: ccmce_engine.sv
// Continuity-check engine for one endpoint with its APB register file.
`timescale 1ns/1ps
`default_nettype none
// Function
// - With overwrite enabled, stamp stored Tx sequence into outgoing frames.
// - Every valid outgoing frame adds one to stored Tx sequence.
// - Outgoing RDI flag is replaced by the configured Tx RDI.
// - Valid received frame sets seen flag; loss frames set loss-seen flag.
// - With check on, mismatch against last plus one flags and counts error.
// - Received sequence number is saved after the check.
// - RDI change sets change flag, may interrupt, and stores new RDI.
// - Valid received frame clears the miss counter.
// - Frame arriving in lost state sets lost flag and clears the state.
// - Separate counters for valid and invalid received frames.
// - One-shot copy of next frame, plus copy-all enables per kind.
// - Record last source port, member port for aggregates.
// - Count consecutive frames on that port; reset on port change.
// - Count reaching global threshold sets stable flag, may interrupt.
// - Parse port and interface TLVs only first; others flag end error.
// - Store received status TLV values; changes set flags, may interrupt.
// - Three-bit miss counter steps on the selected period timer.
// - Miss count seven sets lost state; any change sets lost flag.
// - Insert-next flag turns next outgoing frame into loss frame, self-clears.
// - Insert-next is set by software or by the selected timer.
// - With processing off, frames pass unmodified and checks are skipped.
// - Loss frame needs both enables and a non-zero payload counter, unless insert-next forces it.
module ccmce_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ccmce_pkg::AW-1:0] paddr,
  input wire logic [ccmce_pkg::DW-1:0] pwdata,
  output logic [ccmce_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ccmce_pkg::TMR_N-1:0] timer_expire,
  input wire logic tx_valid,
  input wire logic [ccmce_pkg::SEQ_W-1:0] tx_seq_in,
  input wire logic tx_rdi_in,
  input wire logic tx_lm_nonzero,
  output logic tx_out_valid,
  output logic [ccmce_pkg::SEQ_W-1:0] tx_out_seq,
  output logic tx_out_rdi,
  output logic tx_out_loss,
  output logic tx_out_insert,
  input wire logic rx_valid,
  input wire logic rx_invalid,
  input wire logic [ccmce_pkg::SEQ_W-1:0] rx_seq,
  input wire logic rx_rdi,
  input wire logic rx_lm_nonzero,
  input wire logic [ccmce_pkg::PORT_W-1:0] rx_port,
  input wire logic rx_is_lag,
  input wire logic [ccmce_pkg::PORT_W-1:0] rx_member,
  input wire logic [ccmce_pkg::TLV_W-1:0] rx_t0_type,
  input wire logic [ccmce_pkg::TLV_W-1:0] rx_t0_val,
  input wire logic [ccmce_pkg::TLV_W-1:0] rx_t1_type,
  input wire logic [ccmce_pkg::TLV_W-1:0] rx_t1_val,
  output logic rx_copy_cpu,
  output logic rx_tlv_err,
  output logic irq
);
  import ccmce_pkg::*;

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_r;
  logic [IRQ_N-1:0] irq_en_r;
  logic [ST_N-1:0] sticky_r;
  logic [ST_N-1:0] sticky_set;
  logic [SEQ_W-1:0] tx_seq_r;
  logic [SEQ_W-1:0] rx_seq_r;
  logic rdi_last_r;
  logic [PORT_W-1:0] src_r;
  logic [RUN_W-1:0] run_r;
  logic [RUN_W-1:0] run_nxt;
  logic [RUN_W-1:0] thresh_r;
  logic [TLV_W-1:0] pst_r;
  logic [TLV_W-1:0] ifs_r;
  logic [CNT_W-1:0] good_r;
  logic [CNT_W-1:0] bad_r;
  logic [CNT_W-1:0] seqerr_r;
  logic ins_r;
  logic nxt_r;
  logic [DW-1:0] rd_nxt;
  logic hit;
  logic acc;
  logic wr;
  logic hw_en;
  logic rx_go;
  logic rx_loss;
  logic seq_bad;
  logic ins_go;
  logic ins_set;
  logic tick;
  logic [PORT_W-1:0] src;
  logic port_vld;
  logic if_vld;
  logic end_err;
  logic [TLV_W-1:0] port_val;
  logic [TLV_W-1:0] if_val;
  logic [MISS_W-1:0] miss_cnt;
  logic loc;
  logic loc_set;
  logic loc_clr;

  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign hw_en = ctrl_r[C_HW];
  assign rx_go = rx_valid && hw_en;
  assign rx_loss = rx_go && ctrl_r[C_LOSS] && rx_lm_nonzero;
  assign seq_bad = rx_go && ctrl_r[C_CHK] && rx_seq != rx_seq_r + 32'h1;
  assign ins_go = tx_valid && hw_en && ins_r;
  assign tick = timer_expire[ctrl_r[C_MSEL +: SEL_W]] && hw_en;
  assign ins_set = timer_expire[ctrl_r[C_LSEL +: SEL_W]]
    || (wr && paddr == A_STAT && pwdata[M_INS]);
  assign src = rx_is_lag ? rx_member : rx_port;
  assign run_nxt = (src != src_r) ? '0
    : (run_r == RUN_MAX) ? run_r : run_r + 16'h1;

  ccmce_tlv_parse u_ccmce_tlv_parse (
    .t0_type(rx_t0_type),
    .t0_val(rx_t0_val),
    .t1_type(rx_t1_type),
    .t1_val(rx_t1_val),
    .port_vld(port_vld),
    .port_val(port_val),
    .if_vld(if_vld),
    .if_val(if_val),
    .end_err(end_err)
  );

  ccmce_miss_track u_ccmce_miss_track (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .clear(rx_go),
    .count(miss_cnt),
    .loc(loc),
    .loc_set(loc_set),
    .loc_clr(loc_clr)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state keeps prdata and pready straight from flip-flops.
  always_comb begin
    rd_nxt = '0;
    hit = 1'b1;
    unique case (paddr)
      A_CTRL: rd_nxt[CTRL_W-1:0] = ctrl_r;
      A_IRQEN: rd_nxt[IRQ_N-1:0] = irq_en_r;
      A_STICKY: rd_nxt[ST_N-1:0] = sticky_r;
      A_TXSEQ: rd_nxt = tx_seq_r;
      A_RXSEQ: rd_nxt = rx_seq_r;
      A_LAST: begin
        rd_nxt[L_RDI] = rdi_last_r;
        rd_nxt[L_LOC] = loc;
        rd_nxt[L_SRC +: PORT_W] = src_r;
        rd_nxt[L_PST +: TLV_W] = pst_r;
        rd_nxt[L_IFS +: TLV_W] = ifs_r;
      end
      A_STAT: begin
        rd_nxt[M_CNT +: MISS_W] = miss_cnt;
        rd_nxt[M_INS] = ins_r;
        rd_nxt[M_NXT] = nxt_r;
        rd_nxt[M_RUN +: RUN_W] = run_r;
      end
      A_GOOD: rd_nxt = good_r;
      A_BAD: rd_nxt = bad_r;
      A_SEQERR: rd_nxt = seqerr_r;
      A_THRESH: rd_nxt[RUN_W-1:0] = thresh_r;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= (psel && penable && !pready && !pwrite && hit) ? rd_nxt : '0;
      pslverr <= psel && penable && !pready && !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      irq_en_r <= '0;
      thresh_r <= THRESH_RST;
    end else if (wr) begin
      if (paddr == A_CTRL) ctrl_r <= pwdata[CTRL_W-1:0];
      if (paddr == A_IRQEN) irq_en_r <= pwdata[IRQ_N-1:0];
      if (paddr == A_THRESH) thresh_r <= pwdata[RUN_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    sticky_set = '0;
    sticky_set[S_SEEN] = rx_go;
    sticky_set[S_LSEEN] = rx_loss;
    sticky_set[S_SEQ] = seq_bad;
    sticky_set[S_RDI] = rx_go && rx_rdi != rdi_last_r;
    sticky_set[S_LOC] = loc_set || loc_clr;
    sticky_set[S_PST] = rx_go && src == src_r
      && run_nxt == thresh_r && run_r != thresh_r;
    sticky_set[S_PORT] = rx_go && port_vld && port_val != pst_r;
    sticky_set[S_IF] = rx_go && if_vld && if_val != ifs_r;
  end

  // Set wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_r <= '0;
    end else begin
      sticky_r <= (sticky_r & ~((wr && paddr == A_STICKY)
        ? pwdata[ST_N-1:0] : '0)) | sticky_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sticky_r[IRQ_N-1:0] & irq_en_r);
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_seq_r <= '0;
    end else if (wr && paddr == A_TXSEQ) begin
      tx_seq_r <= pwdata;
    end else if (tx_valid) begin
      tx_seq_r <= tx_seq_r + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out_valid <= 1'b0;
      tx_out_seq <= '0;
      tx_out_rdi <= 1'b0;
      tx_out_loss <= 1'b0;
      tx_out_insert <= 1'b0;
    end else begin
      tx_out_valid <= tx_valid;
      tx_out_seq <= (hw_en && ctrl_r[C_OVW]) ? tx_seq_r : tx_seq_in;
      tx_out_rdi <= hw_en ? ctrl_r[C_RDI] : tx_rdi_in;
      tx_out_loss <= tx_valid && hw_en && (ins_go
        || (ctrl_r[C_LOSS] && tx_lm_nonzero));
      tx_out_insert <= ins_go;
    end
  end

  // A timer expiry that meets an insertion keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ins_r <= 1'b0;
    end else begin
      ins_r <= (ins_r && !ins_go) || ins_set;
    end
  end

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_seq_r <= '0;
      rdi_last_r <= 1'b0;
      src_r <= '0;
      run_r <= '0;
      pst_r <= '0;
      ifs_r <= '0;
    end else begin
      if (wr && paddr == A_RXSEQ) begin
        rx_seq_r <= pwdata;
      end else if (rx_go) begin
        rx_seq_r <= rx_seq;
      end
      if (rx_go) begin
        rdi_last_r <= rx_rdi;
        src_r <= src;
        run_r <= run_nxt;
      end
      if (rx_go && port_vld) pst_r <= port_val;
      if (rx_go && if_vld) ifs_r <= if_val;
    end
  end

  // Counters wrap; software reads differences between samples.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      good_r <= '0;
      bad_r <= '0;
      seqerr_r <= '0;
    end else begin
      if (rx_valid) good_r <= good_r + 32'h1;
      if (rx_invalid) bad_r <= bad_r + 32'h1;
      if (seq_bad) seqerr_r <= seqerr_r + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nxt_r <= 1'b0;
      rx_copy_cpu <= 1'b0;
      rx_tlv_err <= 1'b0;
    end else begin
      nxt_r <= (nxt_r && !rx_go)
        || (wr && paddr == A_STAT && pwdata[M_NXT]);
      rx_copy_cpu <= rx_go && (nxt_r
        || (rx_loss ? ctrl_r[C_CPL] : ctrl_r[C_CPA]));
      rx_tlv_err <= rx_go && end_err;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tx_seq_stamp: assert property (
    tx_valid && hw_en && ctrl_r[C_OVW] |=> tx_out_seq == $past(tx_seq_r))
    else $error("tx sequence not stamped");
  a_tx_seq_count: assert property (
    tx_valid && !(wr && paddr == A_TXSEQ)
    |=> tx_seq_r == $past(tx_seq_r) + 32'h1)
    else $error("tx sequence not advanced");
  a_tx_rdi_set: assert property (
    tx_valid && hw_en |=> tx_out_valid && tx_out_rdi == $past(ctrl_r[C_RDI]))
    else $error("tx rdi not replaced");
  a_rx_seen_flag: assert property (
    rx_go |=> sticky_r[S_SEEN])
    else $error("seen flag not set");
  a_seq_err_count: assert property (
    seq_bad |=> seqerr_r == $past(seqerr_r) + 32'h1 && sticky_r[S_SEQ])
    else $error("sequence error not counted");
  a_rx_seq_save: assert property (
    rx_go && !(wr && paddr == A_RXSEQ) |=> rx_seq_r == $past(rx_seq))
    else $error("rx sequence not saved");
  a_miss_clear: assert property (
    rx_go |=> miss_cnt == '0 && !loc)
    else $error("miss count not cleared");
  a_miss_hold: assert property (
    miss_cnt == MISS_MAX && !rx_go |=> miss_cnt == MISS_MAX)
    else $error("miss count left saturation");
  a_loc_state: assert property (
    miss_cnt == MISS_MAX |-> loc)
    else $error("lost state missing at seven");
  a_insert_clear: assert property (
    ins_go && !ins_set |=> !ins_r ##0 tx_out_insert && tx_out_loss)
    else $error("insert flag not consumed");

  c_loss_insert: cover property (ins_go ##1 tx_out_insert);
  c_loc_enter: cover property (loc_set ##1 loc ##[1:60] loc_clr);
  c_port_stable: cover property (sticky_set[S_PST]);
  c_seq_error: cover property (seq_bad);
endmodule
`default_nettype wire

// File: ccmce_engine_bench.sv
// Self-checking bench for the continuity-check engine.
`timescale 1ns/1ps
`default_nettype none
module ccmce_engine_bench;
  import ccmce_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [DW-1:0] pwdata = '0;
  logic [TMR_N-1:0] tmr = '0;
  logic [DW-1:0] prdata, q;
  logic pready, pslverr, err;
  logic tx_valid, tx_rdi_in, tx_lm_nonzero, rx_valid, rx_invalid;
  logic rx_rdi, rx_lm_nonzero, rx_is_lag;
  logic [SEQ_W-1:0] tx_seq_in, rx_seq, tx_out_seq;
  logic [PORT_W-1:0] rx_port, rx_member;
  logic [31:0] rx_tlv;
  logic tx_out_valid, tx_out_rdi, tx_out_loss, tx_out_insert;
  logic rx_copy_cpu, rx_tlv_err, irq;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;

  always #4 pclk = ~pclk;

  ccmce_peer u_ccmce_peer (.pclk, .tx_valid, .tx_seq_in, .tx_rdi_in,
    .tx_lm_nonzero, .rx_valid, .rx_invalid, .rx_seq, .rx_rdi,
    .rx_lm_nonzero, .rx_port, .rx_is_lag, .rx_member, .rx_tlv);

  ccmce_engine u_ccmce_engine (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_expire(tmr),
    .tx_valid, .tx_seq_in, .tx_rdi_in, .tx_lm_nonzero, .tx_out_valid,
    .tx_out_seq, .tx_out_rdi, .tx_out_loss, .tx_out_insert, .rx_valid,
    .rx_invalid, .rx_seq, .rx_rdi, .rx_lm_nonzero, .rx_port, .rx_is_lag,
    .rx_member, .rx_t0_type(rx_tlv[7:0]), .rx_t0_val(rx_tlv[15:8]),
    .rx_t1_type(rx_tlv[23:16]), .rx_t1_val(rx_tlv[31:24]), .rx_copy_cpu,
    .rx_tlv_err, .irq);

  // ------
  // Tasks
  // ------
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One wait state is expected, but the loop waits for pready itself.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    {q, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    check(q, e);
  endtask

  task automatic tick(input int b, input int n);
    repeat (n) begin
      @(posedge pclk);
      tmr <= 8'h01 << b;
      @(posedge pclk);
      tmr <= '0;
    end
  endtask

  task automatic txc(input logic [31:0] s, input logic l, input logic [35:0] e);
    u_ccmce_peer.tx(s, 1'b0, l);
    #1;
    check({tx_out_valid, tx_out_rdi, tx_out_loss, tx_out_insert,
      tx_out_seq}, e);
  endtask

  task automatic rxc(input logic [31:0] s, input logic l, input logic [12:0] p,
    input logic [31:0] t, input logic [1:0] e);
    u_ccmce_peer.rx(1'b0, s, 1'b1, l, p, t);
    #1;
    check({rx_copy_cpu, rx_tlv_err}, e);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  // ------
  // Tests
  // ------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTRL, 32'h0);
    rd(A_THRESH, 32'h3);
    rd(8'h30, 32'h0);
    check(err, 1'b1);
    txc(32'h99, 1'b1, {4'b1000, 32'h99});
    rxc(32'h3, 1'b0, 13'h3, 32'h7, 2'b00);
    rd(A_STICKY, 32'h0);
    check(irq, 1'b0);
    $display("test reset done");
    apb(1'b1, A_CTRL, 32'h89d);
    apb(1'b1, A_TXSEQ, 32'h10);
    txc(32'h99, 1'b1, {4'b1100, 32'h10});
    rd(A_TXSEQ, 32'h11);
    apb(1'b1, A_CTRL, 32'h89b);
    txc(32'h99, 1'b1, {4'b1110, 32'h99});
    rd(A_TXSEQ, 32'h12);
    apb(1'b1, A_STAT, 32'h8);
    txc(32'h5, 1'b0, {4'b1111, 32'h5});
    rd(A_STAT, 32'h0);
    tick(2, 1);
    txc(32'h6, 1'b0, {4'b1111, 32'h6});
    txc(32'h7, 1'b0, {4'b1100, 32'h7});
    $display("test tx done");
    apb(1'b1, A_RXSEQ, 32'h5);
    apb(1'b1, A_IRQEN, 32'h1f);
    rxc(32'h6, 1'b0, 13'h3, 32'h0, 2'b00);
    rd(A_STICKY, 32'h21);
    check(irq, 1'b1);
    rxc(32'h9, 1'b0, 13'h3, 32'h0, 2'b00);
    rd(A_STICKY, 32'ha1);
    rd(A_SEQERR, 32'h1);
    rd(A_RXSEQ, 32'h9);
    rxc(32'ha, 1'b1, 13'h3, 32'h0, 2'b00);
    rxc(32'hb, 1'b0, 13'h3, 32'h0, 2'b00);
    rd(A_STICKY, 32'he5);
    rd(A_STAT, 32'h300);
    rxc(32'hc, 1'b0, {1'b1, 6'h7, 6'h9}, 32'h0, 2'b00);
    rd(A_LAST, 32'h71);
    rd(A_STAT, 32'h0);
    u_ccmce_peer.rx(1'b1, 32'h0, 1'b0, 1'b0, 13'h3, 32'h0);
    rd(A_BAD, 32'h1);
    rd(A_GOOD, 32'h6);
    $display("test rx done");
    apb(1'b1, A_STICKY, 32'hff);
    apb(1'b1, A_STAT, 32'h10);
    rxc(32'hd, 1'b0, 13'h7, 32'h33045a02, 2'b10);
    rd(A_LAST, 32'h335a0071);
    rd(A_STICKY, 32'h38);
    rxc(32'he, 1'b0, 13'h7, 32'h5a023304, 2'b00);
    rxc(32'hf, 1'b0, 13'h7, 32'h5a020007, 2'b01);
    $display("test status done");
    apb(1'b1, A_STICKY, 32'hff);
    tick(1, 8);
    rd(A_STAT, 32'h307);
    rd(A_LAST, 32'h335a0073);
    rd(A_STICKY, 32'h2);
    apb(1'b1, A_STICKY, 32'hff);
    apb(1'b1, A_CTRL, 32'h8bb);
    rxc(32'h10, 1'b0, 13'h7, 32'h0, 2'b10);
    rd(A_LAST, 32'h335a0071);
    rd(A_STICKY, 32'h22);
    rd(A_STAT, 32'h400);
    $display("test miss done");
    end_sim();
  end
endmodule
`default_nettype wire

// File: ccmce_miss_track.sv
// Saturating miss counter and loss-of-continuity state for one endpoint.
`timescale 1ns/1ps
`default_nettype none
module ccmce_miss_track (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic clear,
  output logic [ccmce_pkg::MISS_W-1:0] count,
  output logic loc,
  output logic loc_set,
  output logic loc_clr
);
  import ccmce_pkg::*;

  // A received frame outranks a timer expiry in the same cycle.
  assign loc_set = tick && !clear && count == MISS_PRE;
  assign loc_clr = clear && loc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick && count != MISS_MAX) begin
      count <= count + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loc <= 1'b0;
    end else if (clear) begin
      loc <= 1'b0;
    end else if (loc_set) begin
      loc <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: ccmce_peer.sv
// Frame lookup model that feeds outgoing and received CCM frames.
`timescale 1ns/1ps
`default_nettype none
module ccmce_peer (
  input wire logic pclk,
  output logic tx_valid,
  output logic [31:0] tx_seq_in,
  output logic tx_rdi_in,
  output logic tx_lm_nonzero,
  output logic rx_valid,
  output logic rx_invalid,
  output logic [31:0] rx_seq,
  output logic rx_rdi,
  output logic rx_lm_nonzero,
  output logic [5:0] rx_port,
  output logic rx_is_lag,
  output logic [5:0] rx_member,
  output logic [31:0] rx_tlv
);
  initial begin
    {tx_valid, tx_seq_in, tx_rdi_in, tx_lm_nonzero} = '0;
    {rx_valid, rx_invalid, rx_seq, rx_rdi, rx_lm_nonzero} = '0;
    {rx_port, rx_is_lag, rx_member, rx_tlv} = '0;
  end

  // Fields go stale after the pulse, so nothing may lean on old values.
  task automatic tx(input logic [31:0] s, input logic r, input logic l);
    @(posedge pclk);
    tx_valid <= 1'b1;
    {tx_seq_in, tx_rdi_in, tx_lm_nonzero} <= {s, r, l};
    @(posedge pclk);
    tx_valid <= 1'b0;
    {tx_seq_in, tx_rdi_in} <= {~s, ~r};
  endtask

  // The port word packs aggregate flag, member port and port.
  task automatic rx(input logic bad, input logic [31:0] s, input logic r,
    input logic l, input logic [12:0] p, input logic [31:0] t);
    @(posedge pclk);
    {rx_invalid, rx_valid} <= {bad, ~bad};
    {rx_seq, rx_rdi, rx_lm_nonzero} <= {s, r, l};
    {rx_is_lag, rx_member, rx_port} <= p;
    rx_tlv <= t;
    @(posedge pclk);
    {rx_invalid, rx_valid} <= 2'b00;
    {rx_seq, rx_rdi, rx_tlv} <= {~s, ~r, ~t};
  endtask
endmodule
`default_nettype wire

// File: ccmce_pkg.sv
// Package with constants, register map and field layout of the engine.
package ccmce_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SEQ_W = 32;
  localparam int CNT_W = 32;
  localparam int PORT_W = 6;
  localparam int TLV_W = 8;
  localparam int RUN_W = 16;
  localparam int MISS_W = 3;
  localparam int SEL_W = 3;
  localparam int TMR_N = 8;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int CTRL_W = 13;
  localparam int IRQ_N = 5;
  localparam int ST_N = 8;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_IRQEN = 8'h04;
  localparam logic [AW-1:0] A_STICKY = 8'h08;
  localparam logic [AW-1:0] A_TXSEQ = 8'h0c;
  localparam logic [AW-1:0] A_RXSEQ = 8'h10;
  localparam logic [AW-1:0] A_LAST = 8'h14;
  localparam logic [AW-1:0] A_STAT = 8'h18;
  localparam logic [AW-1:0] A_GOOD = 8'h1c;
  localparam logic [AW-1:0] A_BAD = 8'h20;
  localparam logic [AW-1:0] A_SEQERR = 8'h24;
  localparam logic [AW-1:0] A_THRESH = 8'h28;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C_HW = 0;
  localparam int C_LOSS = 1;
  localparam int C_OVW = 2;
  localparam int C_CHK = 3;
  localparam int C_RDI = 4;
  localparam int C_CPA = 5;
  localparam int C_CPL = 6;
  localparam int C_MSEL = 7;
  localparam int C_LSEL = 10;
  localparam int S_RDI = 0;
  localparam int S_LOC = 1;
  localparam int S_PST = 2;
  localparam int S_PORT = 3;
  localparam int S_IF = 4;
  localparam int S_SEEN = 5;
  localparam int S_LSEEN = 6;
  localparam int S_SEQ = 7;
  localparam int L_RDI = 0;
  localparam int L_LOC = 1;
  localparam int L_SRC = 4;
  localparam int L_PST = 16;
  localparam int L_IFS = 24;
  localparam int M_CNT = 0;
  localparam int M_INS = 3;
  localparam int M_NXT = 4;
  localparam int M_RUN = 8;
  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
  localparam logic [RUN_W-1:0] THRESH_RST = 16'h0003;
  localparam logic [RUN_W-1:0] RUN_MAX = 16'hffff;
  localparam logic [MISS_W-1:0] MISS_MAX = 3'h7;
  localparam logic [MISS_W-1:0] MISS_PRE = 3'h6;
  localparam logic [TLV_W-1:0] T_END = 8'h00;
  localparam logic [TLV_W-1:0] T_PORT = 8'h02;
  localparam logic [TLV_W-1:0] T_IF = 8'h04;
endpackage

// File: ccmce_tlv_parse.sv
// Status TLV parser for the two TLV slots that follow the CCM header.
`timescale 1ns/1ps
`default_nettype none
module ccmce_tlv_parse (
  input wire logic [ccmce_pkg::TLV_W-1:0] t0_type,
  input wire logic [ccmce_pkg::TLV_W-1:0] t0_val,
  input wire logic [ccmce_pkg::TLV_W-1:0] t1_type,
  input wire logic [ccmce_pkg::TLV_W-1:0] t1_val,
  output logic port_vld,
  output logic [ccmce_pkg::TLV_W-1:0] port_val,
  output logic if_vld,
  output logic [ccmce_pkg::TLV_W-1:0] if_val,
  output logic end_err
);
  import ccmce_pkg::*;
  logic first_port;
  logic first_if;

  // Only the leading slots are looked at; a foreign TLV ends parsing.
  always_comb begin
    first_port = (t0_type == T_PORT);
    first_if = (t0_type == T_IF);
    port_vld = first_port;
    if_vld = first_if;
    port_val = t0_val;
    if_val = t0_val;
    end_err = 1'b0;
    if (!first_port && !first_if && t0_type != T_END) begin
      end_err = 1'b1;
    end
    if (first_port && t1_type == T_IF) begin
      if_vld = 1'b1;
      if_val = t1_val;
    end else if (first_if && t1_type == T_PORT) begin
      port_vld = 1'b1;
      port_val = t1_val;
    end else if ((first_port || first_if) && t1_type != T_END) begin
      end_err = 1'b1;
    end
  end
endmodule
`default_nettype wire
